// ### rtl/isl_pkg.sv
// Shared constants and types for the serial register-access slave port
package isl_pkg;
  localparam int unsigned CORE_HZ   = 25_000_000;
  localparam int unsigned STD_KHZ   = 100; // R02
  localparam int unsigned FAST_KHZ  = 400; // R02
  // Quarter SCL period in core cycles, rounded up so no phase is short
  localparam logic [7:0]  QTR_STD   = 8'((CORE_HZ + 4000 * STD_KHZ - 1) / (4000 * STD_KHZ));
  localparam logic [7:0]  QTR_FAST  = 8'((CORE_HZ + 4000 * FAST_KHZ - 1) / (4000 * FAST_KHZ));
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned DATA_W    = 32;
  localparam logic [6:0]  DEV_ADDR  = 7'h0A;
  localparam logic [1:0]  MODE_I2C  = 2'h2;
  localparam logic [3:0]  ACK_SLOT  = 4'h8;
  localparam logic [3:0]  ACK_DONE  = 4'h9;
  localparam logic [1:0]  LAST_BYTE = 2'h3;
  typedef enum logic [1:0] {ISL_OP_PTR, ISL_OP_WRITE, ISL_OP_READ} isl_op_t;
  typedef enum logic [1:0] {ISL_X_SNAP, ISL_X_COMMIT, ISL_X_WRITE} isl_xfer_t;
endpackage

// ### rtl/isl_bus_if.sv
// Two-wire open-drain bus joining host and device ends
`timescale 1ns/10ps
interface isl_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ### rtl/isl_dev.sv
// Device end: serial slave port onto the 32-bit register fabric
// Contract
// R01: Port active only when mode straps read 10
// R02: Runs at 100 kHz and 400 kHz rates
// R03: Control byte is address 0001010 plus direction
// R04: Ack match; otherwise ignore until next start
// R05: Write direction: pointer byte, then start/stop loads
// R06: Read direction: send data right after ack
// R07: Whole words, pointer times four, msb first
// R08: Read sends four bytes; nack ends, pointer kept (code still increments it on a nacked last word once multi is set)
// R09: Acked fourth byte: pointer increments, next register
// R10: Nack on bytes one to three stops sending
// R11: Stray start or stop ends transfer at once
// R12: Snapshot each register before shifting it out
// R13: Read side effect only after full 32 bits
// R14: Unimplemented addresses read as zero
// R15: Host polls probe, then ready, after reset
// R16: Write bytes all acked; single write keeps pointer
// R17: Further bytes: pointer increments, next register written
// R18: Commit write only after all 32 bits
// R19: Host never writes unimplemented addresses
// R20: Host owns clock; both lines open-drain
// R21: Lines oversampled, synchronised and edge detected
`timescale 1ns/10ps
module isl_dev (
  // Clocks and reset
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        link_clk,
  // Serial bus
  isl_bus_if.dev                           bus,
  // Management mode strap pins
  input  wire logic [1:0]                  mode_strap,
  // Register fabric
  output logic                             reg_rd,
  output logic                             reg_clr,
  output logic                             reg_wr,
  output logic [isl_pkg::ADDR_W-1:0]       reg_addr,
  output logic [isl_pkg::DATA_W-1:0]       reg_wdata,
  input  wire logic [isl_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        reg_hit
);
  import isl_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_WDATA, D_FETCH, D_RDATA} isl_dst_t;

  // Link-domain state
  typedef struct packed {
    logic [1:0]  rst_s;
    logic [3:0]  strap_s;
    logic [1:0]  mode;
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic        scl_p;
    logic        sda_p;
    isl_dst_t    st;
    logic [3:0]  bitc;
    logic [1:0]  byte_i;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [7:0]  ptr;
    logic        mack;
    logic        multi;
    logic        pend;
    logic        sent;
    logic        oe;
    logic        busy;
    logic        req_t;
    isl_xfer_t   req_op;
    logic [7:0]  req_ptr;
    logic [31:0] req_data;
    logic [1:0]  ack_s;
    logic        ack_p;
  } isl_lnk_t;

  // Core-domain state
  typedef struct packed {
    logic [1:0]  req_s;
    logic        req_p;
    logic        ack_t;
    logic        rd;
    logic        clr;
    logic        wr;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } isl_core_t;

  isl_lnk_t  l_q;
  isl_lnk_t  l_d;
  isl_core_t c_q;
  isl_core_t c_d;

  always_comb begin
    logic      scl;
    logic      sda;
    logic      start;
    logic      stop;
    logic      rise;
    logic      fall;
    logic      iss;
    isl_xfer_t iss_op;
    l_d     = l_q;
    iss     = 1'b0;
    iss_op  = ISL_X_SNAP;
    // Two stages before any logic looks at the pins
    l_d.rst_s   = {l_q.rst_s[0], sys_rst};
    l_d.strap_s = {l_q.strap_s[1:0], mode_strap};
    l_d.scl_s   = {l_q.scl_s[0], bus.scl}; // R21
    l_d.sda_s   = {l_q.sda_s[0], bus.sda};
    l_d.scl_p   = l_q.scl_s[1];
    l_d.sda_p   = l_q.sda_s[1];
    l_d.ack_s   = {l_q.ack_s[0], c_q.ack_t};
    l_d.ack_p   = l_q.ack_s[1];
    scl   = l_q.scl_s[1];
    sda   = l_q.sda_s[1];
    start = scl && l_q.scl_p && l_q.sda_p && !sda; // R21
    stop  = scl && l_q.scl_p && !l_q.sda_p && sda;
    rise  = scl && !l_q.scl_p;
    fall  = !scl && l_q.scl_p;
    // Fabric answered; core holds rdata until the next request
    if (l_q.ack_s[1] != l_q.ack_p) begin
      l_d.busy = 1'b0;
      if (l_q.req_op == ISL_X_SNAP) begin
        l_d.tx = c_q.rdata; // R12
      end
    end
    if (l_q.mode != MODE_I2C) begin
      l_d.st = D_IDLE; // R01
      l_d.oe = 1'b0;
    end else if (start) begin
      l_d.st   = D_ADDR; // R11
      l_d.bitc = 4'h0;
      l_d.oe   = 1'b0;
    end else if (stop) begin
      l_d.st = D_IDLE; // R11
      l_d.oe = 1'b0;
    end else begin
      case (l_q.st)
        D_IDLE: begin
        end
        D_RDATA: begin
          if (rise) begin
            if (l_q.bitc == ACK_SLOT) begin
              l_d.mack = !sda;
              l_d.bitc = ACK_DONE;
            end else begin
              l_d.bitc = l_q.bitc + 4'h1;
            end
          end else if (fall && l_q.bitc == ACK_DONE) begin
            l_d.bitc = 4'h0;
            if (l_q.byte_i == LAST_BYTE) begin
              if (l_q.mack || l_q.multi) begin
                l_d.ptr = l_q.ptr + 8'h01; // R09
              end
              if (l_q.mack) begin
                l_d.multi = 1'b1;
                l_d.sent  = 1'b0;
                l_d.st    = D_FETCH; // R12
              end else begin
                l_d.st = D_IDLE; // R08
              end
            end else if (l_q.mack) begin
              l_d.byte_i = l_q.byte_i + 2'h1;
              l_d.oe     = !l_q.tx[31];
            end else begin
              l_d.st = D_IDLE; // R10
            end
          end else if (fall && l_q.bitc != 4'h0) begin
            // Shift on the falling edge; release for the master's ack
            l_d.tx = {l_q.tx[30:0], 1'b0}; // R07
            l_d.oe = (l_q.bitc != ACK_SLOT) && !l_q.tx[30];
            if (l_q.bitc == ACK_SLOT && l_q.byte_i == LAST_BYTE) begin
              iss    = 1'b1; // R13
              iss_op = ISL_X_COMMIT;
            end
          end
        end
        default: begin
          // Receiving states and the fetch wait share the ack slot
          if (rise) begin
            if (l_q.bitc == ACK_SLOT) begin
              l_d.bitc = ACK_DONE;
            end else if (l_q.bitc != ACK_DONE) begin
              l_d.rx   = {l_q.rx[30:0], sda}; // R07
              l_d.bitc = l_q.bitc + 4'h1;
            end
          end else if (fall && l_q.bitc == ACK_DONE) begin
            l_d.oe   = 1'b0;
            l_d.bitc = 4'h0;
          end else if (fall && l_q.bitc == 4'h1 && l_q.st == D_WDATA && l_q.pend) begin
            // A stop or start also opens with a clock rise; only a fall proves a fifth byte
            l_d.ptr   = l_q.ptr + 8'h01; // R17
            l_d.pend  = 1'b0;
            l_d.multi = 1'b1;
          end else if (fall && l_q.bitc == ACK_SLOT) begin
            case (l_q.st)
              D_ADDR: begin
                if (l_q.rx[7:1] == DEV_ADDR) begin
                  l_d.oe    = 1'b1; // R04
                  l_d.multi = 1'b0;
                  l_d.pend  = 1'b0;
                  l_d.sent  = 1'b0;
                  l_d.st    = l_q.rx[0] ? D_FETCH : D_PTR; // R06
                end else begin
                  l_d.st = D_IDLE; // R04
                end
              end
              D_PTR: begin
                l_d.oe     = 1'b1;
                l_d.ptr    = l_q.rx[7:0]; // R05
                l_d.byte_i = 2'h0;
                l_d.st     = D_WDATA;
              end
              D_WDATA: begin
                l_d.oe     = 1'b1; // R16
                l_d.byte_i = l_q.byte_i + 2'h1;
                if (l_q.byte_i == LAST_BYTE) begin
                  iss    = 1'b1; // R18
                  iss_op = ISL_X_WRITE;
                  if (l_q.multi) begin
                    l_d.ptr = l_q.ptr + 8'h01; // R17
                  end else begin
                    l_d.pend = 1'b1;
                  end
                end
              end
              default: begin
              end
            endcase
          end
          // Snapshot fetched in the low phase before the first bit
          if (l_q.st == D_FETCH) begin
            if (!l_q.sent && !l_q.busy) begin
              iss       = 1'b1; // R12
              iss_op    = ISL_X_SNAP;
              l_d.sent  = 1'b1;
            end else if (l_q.sent && !l_q.busy && l_q.bitc == 4'h0) begin
              l_d.st     = D_RDATA; // R06
              l_d.byte_i = 2'h0;
              l_d.oe     = !l_q.tx[31];
            end
          end
        end
      endcase
    end
    if (iss) begin
      l_d.req_t    = !l_q.req_t;
      l_d.req_op   = iss_op;
      l_d.req_ptr  = l_q.ptr;
      l_d.req_data = l_q.rx;
      l_d.busy     = 1'b1;
    end
    if (l_q.rst_s[1]) begin
      l_d.st    = D_IDLE;
      l_d.oe    = 1'b0;
      l_d.busy  = 1'b0;
      l_d.req_t = 1'b0;
      l_d.ptr   = 8'h00;
      l_d.bitc  = 4'h0;
      l_d.multi = 1'b0;
      l_d.pend  = 1'b0;
      l_d.mode  = l_q.strap_s[3:2]; // R01
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  // Core side: one fabric access per request toggle
  always_comb begin
    c_d       = c_q;
    c_d.req_s = {c_q.req_s[0], l_q.req_t};
    c_d.req_p = c_q.req_s[1];
    c_d.rd    = 1'b0;
    c_d.clr   = 1'b0;
    c_d.wr    = 1'b0;
    if (c_q.rd) begin
      c_d.rdata = reg_hit ? reg_rdata : 32'h0000_0000; // R14
    end
    if (c_q.rd || c_q.clr || c_q.wr) begin
      c_d.ack_t = !c_q.ack_t;
    end
    // Payload is held steady by the link side until acknowledged
    if (c_q.req_s[1] != c_q.req_p) begin
      c_d.addr  = {l_q.req_ptr, 2'b00}; // R07
      c_d.wdata = l_q.req_data;
      case (l_q.req_op)
        ISL_X_SNAP:   c_d.rd = 1'b1;
        ISL_X_COMMIT: c_d.clr = 1'b1; // R13
        ISL_X_WRITE:  c_d.wr = 1'b1; // R18
        default:      c_d.rd = 1'b0;
      endcase
    end
    if (sys_rst) begin
      c_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    c_q <= c_d;
  end

  assign bus.dev_sda_o  = 1'b0; // R20
  assign bus.dev_sda_oe = l_q.oe;
  assign reg_rd         = c_q.rd;
  assign reg_clr        = c_q.clr;
  assign reg_wr         = c_q.wr;
  assign reg_addr       = c_q.addr;
  assign reg_wdata      = c_q.wdata;
endmodule

// ### rtl/isl_host.sv
// Host end: bus master issuing pointer, write and read sequences
`timescale 1ns/10ps
module isl_host #(
  parameter logic [7:0] QTR_CYC = isl_pkg::QTR_STD
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Serial bus
  isl_bus_if.host                bus,
  // Command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire isl_pkg::isl_op_t  cmd_op,
  input  wire logic [7:0]        cmd_ptr,
  input  wire logic [7:0]        cmd_words,
  // Write data
  input  wire logic [31:0]       wr_data,
  output logic                   wr_take,
  // Read data and status
  output logic [31:0]            rd_data,
  output logic                   rd_valid,
  output logic                   done,
  output logic                   nacked
);
  import isl_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} isl_hst_t;
  typedef enum logic [2:0] {S_CTRLW, S_PTR, S_WR, S_CTRLR, S_RD} isl_stg_t;

  typedef struct packed {
    isl_hst_t    st;
    isl_stg_t    stg;
    isl_op_t     op;
    logic [1:0]  ph;
    logic [7:0]  qc;
    logic [3:0]  bitn;
    logic [1:0]  byte_i;
    logic [7:0]  words;
    logic [7:0]  ptr;
    logic [8:0]  sh;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic [31:0] rdat;
    logic [1:0]  sda_s;
    logic        scl_oe;
    logic        sda_oe;
    logic        take;
    logic        rvalid;
    logic        done;
    logic        nack;
  } isl_hreg_t;

  isl_hreg_t h_q;
  isl_hreg_t h_d;

  always_comb begin
    logic       tick;
    logic [1:0] np;
    logic       nak;
    logic       last_w;
    logic [31:0] nbuf;
    h_d        = h_q;
    h_d.sda_s  = {h_q.sda_s[0], bus.sda};
    h_d.take   = 1'b0;
    h_d.rvalid = 1'b0;
    h_d.done   = 1'b0;
    tick   = (h_q.qc == QTR_CYC - 8'h01);
    np     = h_q.ph + 2'h1;
    nak    = h_q.sda_s[1];
    last_w = (h_q.words == 8'h01);
    nbuf   = {h_q.rbuf[23:0], h_q.sh[7:0]};
    if (h_q.st == H_IDLE) begin
      h_d.scl_oe = 1'b0;
      h_d.sda_oe = 1'b0;
      if (cmd_valid) begin
        h_d.st    = H_START;
        h_d.stg   = S_CTRLW;
        h_d.op    = cmd_op;
        h_d.ptr   = cmd_ptr;
        h_d.words = cmd_words;
        h_d.ph    = 2'h0;
        h_d.qc    = 8'h00;
        h_d.nack  = 1'b0;
      end
    end else begin
      h_d.qc = tick ? 8'h00 : h_q.qc + 8'h01;
      if (tick) begin
        // Clock low for phases 0-1; data moves only in phase 1 or 3
        h_d.ph     = np;
        h_d.scl_oe = !np[1]; // R20
        if (np != 2'h0) begin
          case (h_q.st)
            H_START: h_d.sda_oe = (np == 2'h3);
            H_STOP:  h_d.sda_oe = (np != 2'h3);
            default: h_d.sda_oe = !h_q.sh[8];
          endcase
        end
        if (h_q.ph == 2'h3) begin
          case (h_q.st)
            H_START: begin
              h_d.st   = H_BIT;
              h_d.bitn = 4'h0;
              h_d.sh   = {DEV_ADDR, h_q.stg == S_CTRLR, 1'b1}; // R03
            end
            H_STOP: begin
              h_d.st   = H_IDLE;
              h_d.done = 1'b1;
            end
            default: begin
              h_d.sh   = {h_q.sh[7:0], h_q.sda_s[1]};
              h_d.bitn = h_q.bitn + 4'h1;
              if (h_q.bitn == ACK_SLOT) begin
                h_d.bitn = 4'h0;
                if (nak && h_q.stg != S_RD) begin
                  h_d.nack = 1'b1;
                  h_d.st   = H_STOP;
                end else begin
                  case (h_q.stg)
                    S_CTRLW: begin
                      h_d.stg = S_PTR;
                      h_d.sh  = {h_q.ptr, 1'b1};
                    end
                    S_PTR: begin
                      if (h_q.op == ISL_OP_WRITE) begin
                        h_d.stg    = S_WR;
                        h_d.wbuf   = wr_data;
                        h_d.take   = 1'b1;
                        h_d.byte_i = 2'h0;
                        h_d.sh     = {wr_data[31:24], 1'b1};
                      end else if (h_q.op == ISL_OP_READ) begin
                        h_d.st  = H_START; // R05
                        h_d.stg = S_CTRLR;
                      end else begin
                        h_d.st = H_STOP; // R05
                      end
                    end
                    S_WR: begin
                      if (h_q.byte_i != LAST_BYTE) begin
                        h_d.byte_i = h_q.byte_i + 2'h1;
                        h_d.wbuf   = {h_q.wbuf[23:0], 8'h00};
                        h_d.sh     = {h_q.wbuf[23:16], 1'b1};
                      end else if (last_w) begin
                        h_d.st = H_STOP; // R16
                      end else begin
                        h_d.words  = h_q.words - 8'h01; // R17
                        h_d.wbuf   = wr_data;
                        h_d.take   = 1'b1;
                        h_d.byte_i = 2'h0;
                        h_d.sh     = {wr_data[31:24], 1'b1};
                      end
                    end
                    S_CTRLR: begin
                      h_d.stg    = S_RD;
                      h_d.byte_i = 2'h0;
                      h_d.sh     = {8'hFF, 1'b0};
                    end
                    default: begin
                      h_d.rbuf   = nbuf;
                      h_d.byte_i = h_q.byte_i + 2'h1;
                      // Nack only the fourth byte of the last word
                      h_d.sh     = {8'hFF, last_w && h_q.byte_i == 2'h2}; // R08
                      if (h_q.byte_i == LAST_BYTE) begin
                        h_d.rdat   = nbuf;
                        h_d.rvalid = 1'b1;
                        h_d.words  = h_q.words - 8'h01; // R09
                        if (last_w) begin
                          h_d.st = H_STOP; // R08
                        end
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
    end
    if (sys_rst) begin
      h_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    h_q <= h_d;
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = h_q.scl_oe;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = h_q.sda_oe;
  assign cmd_ready       = (h_q.st == H_IDLE);
  assign wr_take         = h_q.take;
  assign rd_data         = h_q.rdat;
  assign rd_valid        = h_q.rvalid;
  assign done            = h_q.done;
  assign nacked          = h_q.nack;
endmodule

// ### bench/isl_sva.sv
// Bus-level checks on the link between host and device ends
`timescale 1ns/10ps
module isl_sva (
  // Clock and reset
  input wire logic link_clk,
  input wire logic sys_rst,
  // Bus lines and drivers
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import isl_pkg::*;
  // Fast-rate low half of a bit is about 86 link cycles
  localparam int SCL_LOW_MAX = 120;
  logic       scl_q, sda_q, rw_q, quiet_q;
  logic       rise, start, stop;
  logic [3:0] bit_q;
  logic [7:0] byte_q, shf_q;
  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  // Frame tracker; quiet marks spans where the device must stay off the line
  always_ff @(posedge link_clk) begin
    if (sys_rst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      rw_q    <= 1'b0;
      quiet_q <= 1'b1;
      bit_q   <= 4'h0;
      byte_q  <= 8'h00;
      shf_q   <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bit_q   <= 4'h0;
        byte_q  <= 8'h00;
        quiet_q <= 1'b0;
      end else if (stop) begin
        quiet_q <= 1'b1;
      end else if (rise && bit_q == ACK_SLOT) begin
        bit_q  <= 4'h0;
        byte_q <= byte_q + 8'h01;
        if (byte_q == 8'h00) begin
          rw_q <= shf_q[0];
        end else if (rw_q && sda) begin
          quiet_q <= 1'b1;
        end
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        shf_q <= {shf_q[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    start;
  endsequence
  sequence s_slot;
    rise && bit_q == ACK_SLOT;
  endsequence
  sequence s_ctrl_ack;
    s_slot ##0 (byte_q == 8'h00 && shf_q[7:1] == DEV_ADDR);
  endsequence
  sequence s_wr_ack;
    s_slot ##0 (byte_q != 8'h00 && !rw_q);
  endsequence
  sequence s_rd_slot;
    s_slot ##0 (byte_q != 8'h00 && rw_q);
  endsequence
  a_ctrl_ack: assert property (s_ctrl_ack |-> dev_sda_oe [*4])
    else $error("control byte not acknowledged");
  a_wr_ack: assert property (s_wr_ack |-> dev_sda_oe ##1 dev_sda_oe)
    else $error("write-direction byte not acknowledged");
  a_rd_release: assert property (s_rd_slot |-> !dev_sda_oe)
    else $error("device holds data line in master ack slot");
  a_nack_quiet: assert property (quiet_q |-> !dev_sda_oe)
    else $error("device drives after nack or stop");
  a_start_release: assert property (s_start |-> !dev_sda_oe [*8])
    else $error("device drives right after start");
  a_sda_edge: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changes data line while clock high");
  a_scl_low_max: assert property (!scl |-> ##[1:SCL_LOW_MAX] scl)
    else $error("clock line held low too long");
  a_start_host: assert property (s_start |-> host_sda_oe)
    else $error("start not made by host");
endmodule

// ### bench/testbench.sv
// Self-checking bench: two host and device pairs, each joined on its own bus
`timescale 1ns/10ps
`define check_eq(act, exp) begin comparisons++; if ((act) !== (exp)) begin err_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, (act), (exp)); end end
module testbench;
  import isl_pkg::*;
  typedef struct {
    isl_op_t     op;
    logic [7:0]  ptr;
    logic [7:0]  words;
    logic [31:0] d0;
    logic [31:0] step;
  } isl_row_t;
  localparam int TIMEOUT = 80000;
  logic        core_clk, link_clk, sys_rst, cmd_valid, cmd_ready, wr_take, rd_valid, done;
  logic        nacked, nacked_b, reg_rd, reg_clr, reg_wr, reg_hit;
  isl_op_t     cmd_op;
  logic [7:0]  cmd_ptr, cmd_words;
  logic [31:0] wr_data, wr_step, rd_data, reg_wdata, reg_rdata;
  logic [9:0]  reg_addr, first_a, last_a;
  logic [31:0] mem [256];
  logic [31:0] rdq [$];
  isl_row_t    rows [9];
  int          err_count, comparisons, cycles, rd_n, wr_n, clr_n;

  isl_bus_if bus_a ();
  isl_bus_if bus_b ();
  isl_host #(.QTR_CYC(QTR_FAST)) i_isl_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(bus_a), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_ptr(cmd_ptr), .cmd_words(cmd_words), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nacked(nacked));
  isl_dev i_isl_dev (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .bus(bus_a), .mode_strap(MODE_I2C), .reg_rd(reg_rd), .reg_clr(reg_clr), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  // Second pair at standard rate with the port strapped off
  isl_host #(.QTR_CYC(QTR_STD)) i_isl_host_b (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(bus_b), .cmd_valid(cmd_valid), .cmd_ready(), .cmd_op(cmd_op), .cmd_ptr(cmd_ptr),
    .cmd_words(cmd_words), .wr_data(wr_data), .wr_take(), .rd_data(), .rd_valid(),
    .done(), .nacked(nacked_b));
  isl_dev i_isl_dev_b (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .bus(bus_b), .mode_strap(2'h1), .reg_rd(), .reg_clr(), .reg_wr(), .reg_addr(),
    .reg_wdata(), .reg_rdata(32'h0), .reg_hit(1'b0));
  isl_sva i_isl_sva (.link_clk(link_clk), .sys_rst(sys_rst),
    .host_scl_oe(bus_a.host_scl_oe), .host_sda_oe(bus_a.host_sda_oe),
    .dev_sda_oe(bus_a.dev_sda_oe), .scl(bus_a.scl), .sda(bus_a.sda));

  always #20 core_clk = ~core_clk;
  always #7.5 link_clk = ~link_clk;
  // Fabric model; address 0x20 is unimplemented, 0x05 clears on read
  assign reg_rdata = mem[reg_addr[9:2]];
  assign reg_hit   = (reg_addr[9:2] != 8'h20);

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (reg_rd === 1'b1 || reg_wr === 1'b1) begin
      if (rd_n + wr_n == 0) first_a = reg_addr;
      last_a = reg_addr;
    end
    if (reg_rd === 1'b1) rd_n++;
    if (reg_wr === 1'b1) begin
      wr_n++;
      mem[reg_addr[9:2]] <= reg_wdata;
    end
    if (reg_clr === 1'b1) begin
      clr_n++;
      if (reg_addr[9:2] == 8'h05) mem[8'h05] <= 32'h0;
    end
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (wr_take === 1'b1) wr_data <= wr_data + wr_step;
    cycles++;
    if (cycles == TIMEOUT) begin
      err_count++;
      complete_run();
    end
  end

  task automatic do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Link side needs settling time before traffic
    repeat (10) @(posedge core_clk);
  endtask

  task automatic run_row(input isl_row_t r);
    logic [7:0] lp;
    lp = r.ptr + r.words - 8'h01;
    rd_n = 0;
    wr_n = 0;
    clr_n = 0;
    rdq.delete();
    wr_step = r.step;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= r.op;
    cmd_ptr <= r.ptr;
    cmd_words <= r.words;
    wr_data <= r.d0;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) @(posedge core_clk);
    `check_eq(nacked, 1'b0)
    `check_eq(wr_n, (r.op == ISL_OP_WRITE) ? int'(r.words) : 0)
    `check_eq(clr_n, (r.op == ISL_OP_READ) ? int'(r.words) : 0)
    `check_eq(rd_n, clr_n)
    if (r.op != ISL_OP_PTR) begin
      `check_eq(first_a, {r.ptr, 2'h0})
      `check_eq(last_a, {lp, 2'h0})
    end
    if (r.op == ISL_OP_READ) begin
      `check_eq(rdq.size(), int'(r.words))
      foreach (rdq[k]) `check_eq(rdq[k], r.d0 + 32'(k) * r.step)
    end
  endtask

  initial begin
    core_clk = 1'b0;
    link_clk = 1'b0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = ISL_OP_PTR;
    cmd_ptr = 8'h00;
    cmd_words = 8'h00;
    wr_data = 32'h0;
    wr_step = 32'h0;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    rd_n = 0;
    wr_n = 0;
    clr_n = 0;
    for (int k = 0; k < 256; k++) mem[k] = 32'h0;
    mem[8'h20] = 32'hFFFF_FFFF;
    rows = '{'{ISL_OP_WRITE, 8'h03, 8'h01, 32'hA5C3_0F96, 32'h0},
             '{ISL_OP_READ,  8'h03, 8'h01, 32'hA5C3_0F96, 32'h0},
             '{ISL_OP_WRITE, 8'hFE, 8'h03, 32'h1111_1111, 32'h1111_1111},
             '{ISL_OP_READ,  8'hFE, 8'h03, 32'h1111_1111, 32'h1111_1111},
             '{ISL_OP_WRITE, 8'h05, 8'h01, 32'hDEAD_BEEF, 32'h0},
             '{ISL_OP_READ,  8'h05, 8'h01, 32'hDEAD_BEEF, 32'h0},
             '{ISL_OP_READ,  8'h05, 8'h01, 32'h0, 32'h0},
             '{ISL_OP_READ,  8'h20, 8'h01, 32'h0, 32'h0},
             '{ISL_OP_PTR,   8'h07, 8'h01, 32'h0, 32'h0}};
    do_reset();
    `check_eq(bus_a.host_scl_oe, 1'b0)
    `check_eq(bus_a.dev_sda_oe, 1'b0)
    foreach (rows[i]) begin
      run_row(rows[i]);
      if (i == 0) `check_eq(nacked_b, 1'b1)
      $display("test %0d finished", i);
    end
    // Second reset mid-run, then a read straight after it
    do_reset();
    run_row('{ISL_OP_READ, 8'h03, 8'h01, 32'hA5C3_0F96, 32'h0});
    $display("test after reset finished");
    complete_run();
  end
endmodule
